// file: design/feature_ctrl_consts.svh
// Constants for the feature control register block
`ifndef FEATURE_CTRL_CONSTS_SVH
`define FEATURE_CTRL_CONSTS_SVH
`define FEAT_ADDR 8'h0e
`define FEAT_RESET 8'h00
`define FEAT_CLK_SEL 0
`define FEAT_SOFT_RST 1
`define FEAT_DECODE 2
`define FEAT_UNUSED 3
`define FEAT_BLINK_EN 4
`define FEAT_BLINK_RATE 5
`define FEAT_SYNC 6
`define FEAT_BLINK_PHASE 7
`define FEAT_WR_MASK 8'hf7
`define RD_MISS_DATA 8'h00
`define MS_PER_S 1000
`define CLK_HZ 50000000
`define BLINK_SHORT_MS 500
`define BLINK_LONG_MS 1000
`endif

// file: design/feature_ctrl_pkg.sv
// Types shared by the feature control register block
package feature_ctrl_pkg;
   typedef logic [7:0] reg_byte_t;
   typedef enum logic {DECODE_CODE_B, DECODE_HEX} decode_style_t;
endpackage

// file: design/pin_sync.sv
// Two flip-flop synchroniser with rising edge detect
`timescale 1ns/1ps
`default_nettype none
module pin_sync (
   input wire logic sys_clk_in,
   input wire logic rst_n_in,
   input wire logic pin_in,
   output logic level_out,
   output logic rise_out
);
   logic meta_ff;
   logic sync_ff;
   logic prev_ff;

   // -----------------------------
   // Synchroniser and edge finder
   // -----------------------------
   // Only sync_ff reads meta_ff, to keep metastability contained
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         meta_ff <= 1'b0;
         sync_ff <= 1'b0;
         prev_ff <= 1'b0;
      end else begin
         meta_ff <= pin_in;
         sync_ff <= meta_ff;
         prev_ff <= sync_ff;
      end
   end

   assign level_out = sync_ff;
   assign rise_out = sync_ff & ~prev_ff;
endmodule // pin_sync
`default_nettype wire

// file: design/blink_timer.sv
// Blink timing counter with selectable half period
`timescale 1ns/1ps
`default_nettype none
`include "feature_ctrl_consts.svh"
module blink_timer #(
   parameter int unsigned SHORT_CYC = (`CLK_HZ / `MS_PER_S) * `BLINK_SHORT_MS,
   parameter int unsigned LONG_CYC = (`CLK_HZ / `MS_PER_S) * `BLINK_LONG_MS
) (
   input wire logic sys_clk_in,
   input wire logic rst_n_in,
   input wire logic clear_in,
   input wire logic long_in,
   output logic half_done_out
);
   logic [31:0] count_ff;
   logic [31:0] limit;

   // Half period is the on or off time
   assign limit = long_in ? 32'(LONG_CYC - 1) : 32'(SHORT_CYC - 1);
   assign half_done_out = (count_ff >= limit) & ~clear_in;

   // -----------------------------
   // Counter
   // -----------------------------
   // >= so a rate change mid-phase never overruns the wrap
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         count_ff <= 32'h0;
      end else if (clear_in || count_ff >= limit) begin
         count_ff <= 32'h0;
      end else begin
         count_ff <= count_ff + 32'h1;
      end
   end
endmodule // blink_timer
`default_nettype wire

// file: design/feature_ctrl.sv
// Feature control register, clock select, soft reset and blink control
//
// Behaviour
// - Read/write eight-bit feature register at 0x0E
// - Register clears to zero at power-up
// - Bit0 selects internal or external clock
// - Bit1 resets other control registers to defaults
// - Digit data registers survive soft reset
// - Bit2 selects code-B or hex decoding
// - Bit4 enables display blinking
// - Bit5 selects one or two second period
// - Bit6 clears timing counter on chip-select rise
// - Bit7 selects first blink phase on/off
`timescale 1ns/1ps
`default_nettype none
`include "feature_ctrl_consts.svh"
module feature_ctrl #(
   parameter int unsigned SHORT_CYC = (`CLK_HZ / `MS_PER_S) * `BLINK_SHORT_MS,
   parameter int unsigned LONG_CYC = (`CLK_HZ / `MS_PER_S) * `BLINK_LONG_MS
) (
   input wire logic sys_clk_in,
   input wire logic rst_n_in,
   input wire logic wr_en_in,
   input wire logic rd_en_in,
   input wire logic [7:0] addr_in,
   input wire feature_ctrl_pkg::reg_byte_t wr_data_in,
   output feature_ctrl_pkg::reg_byte_t rd_data_out,
   output logic rd_hit_out,
   input wire logic load_chip_select_pin_in,
   output logic ext_clk_sel_out,
   output logic ctrl_regs_reset_out,
   output logic digit_data_keep_out,
   output feature_ctrl_pkg::decode_style_t decode_style_out,
   output logic blink_active_out,
   output logic display_on_out
);
   import feature_ctrl_pkg::*;

   reg_byte_t feature_ff;
   reg_byte_t rd_data_ff;
   logic rd_hit_ff;
   logic phase_on_ff;
   logic blink_en_d_ff;
   logic cs_rise;
   logic half_done;
   logic timer_clear;
   logic blink_start;
   logic hit;

   // Address decode shared by read and write
   function automatic logic addr_match(input logic [7:0] a);
      return a == `FEAT_ADDR;
   endfunction

   assign hit = addr_match(addr_in);

   // -----------------------------
   // Register write
   // -----------------------------
   // Power-up and reset clear every bit
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         feature_ff <= `FEAT_RESET;
      end else if (wr_en_in && hit) begin
         feature_ff <= wr_data_in;
         feature_ff[`FEAT_UNUSED] <= 1'b0;
      end
   end

   // -----------------------------
   // Register read
   // -----------------------------
   // Unmapped addresses return zero, flagged by rd_hit_out low
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rd_data_ff <= `RD_MISS_DATA;
         rd_hit_ff <= 1'b0;
      end else if (rd_en_in) begin
         rd_data_ff <= hit ? feature_ff : `RD_MISS_DATA;
         rd_hit_ff <= hit;
      end
   end

   assign rd_data_out = rd_data_ff;
   assign rd_hit_out = rd_hit_ff;

   // -----------------------------
   // Static feature outputs
   // -----------------------------
   assign ext_clk_sel_out = feature_ff[`FEAT_CLK_SEL];
   // Soft reset is a level; the feature register itself is untouched
   assign ctrl_regs_reset_out = feature_ff[`FEAT_SOFT_RST];
   // Digit data registers must not honour the soft reset
   assign digit_data_keep_out = 1'b1;
   assign decode_style_out = feature_ff[`FEAT_DECODE] ?
                             DECODE_HEX : DECODE_CODE_B;

   // -----------------------------
   // Chip-select synchroniser
   // -----------------------------
   pin_sync u_cs_sync (
      .sys_clk_in(sys_clk_in),
      .rst_n_in(rst_n_in),
      .pin_in(load_chip_select_pin_in),
      .level_out(),
      .rise_out(cs_rise)
   );

   // Blink start restarts the timer so the first phase is full length
   assign blink_start = feature_ff[`FEAT_BLINK_EN] & ~blink_en_d_ff;
   assign timer_clear = (feature_ff[`FEAT_SYNC] & cs_rise)
                        | blink_start;

   blink_timer #(
      .SHORT_CYC(SHORT_CYC),
      .LONG_CYC(LONG_CYC)
   ) u_timer (
      .sys_clk_in(sys_clk_in),
      .rst_n_in(rst_n_in),
      .clear_in(timer_clear),
      .long_in(feature_ff[`FEAT_BLINK_RATE]),
      .half_done_out(half_done)
   );

   // -----------------------------
   // Blink phase
   // -----------------------------
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         blink_en_d_ff <= 1'b0;
      end else begin
         blink_en_d_ff <= feature_ff[`FEAT_BLINK_EN];
      end
   end

   // A sync clear restarts in the programmed starting phase as well
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         phase_on_ff <= 1'b1;
      end else if (!feature_ff[`FEAT_BLINK_EN]) begin
         phase_on_ff <= 1'b1;
      end else if (timer_clear) begin
         phase_on_ff <= feature_ff[`FEAT_BLINK_PHASE];
      end else if (half_done) begin
         phase_on_ff <= ~phase_on_ff;
      end
   end

   assign blink_active_out = blink_en_d_ff;
   assign display_on_out = phase_on_ff;

   // -----------------------------
   // Assertions
   // -----------------------------
   sequence s_write_hit;
      wr_en_in && addr_match(addr_in);
   endsequence

   sequence s_write_miss;
      wr_en_in && !addr_match(addr_in);
   endsequence

   sequence s_read_hit;
      rd_en_in && addr_match(addr_in);
   endsequence

   sequence s_read_miss;
      rd_en_in && !addr_match(addr_in);
   endsequence

   sequence s_reset_left;
      $rose(rst_n_in);
   endsequence

   property p_write_store;
      @(posedge sys_clk_in) disable iff (!rst_n_in)
      s_write_hit |=> feature_ff == ($past(wr_data_in) & `FEAT_WR_MASK);
   endproperty
   a_write_store: assert property (p_write_store)
      else $error("feature write not stored");

   property p_read_back;
      @(posedge sys_clk_in) disable iff (!rst_n_in)
      s_read_hit |=> rd_data_out == $past(feature_ff);
   endproperty
   a_read_back: assert property (p_read_back)
      else $error("feature read wrong");

   property p_clk_sel;
      @(posedge sys_clk_in) disable iff (!rst_n_in)
      s_write_hit |=> ext_clk_sel_out == $past(wr_data_in[`FEAT_CLK_SEL]);
   endproperty
   a_clk_sel: assert property (p_clk_sel)
      else $error("clock select mismatch");

   property p_soft_rst;
      @(posedge sys_clk_in) disable iff (!rst_n_in)
      s_write_hit |=> ctrl_regs_reset_out
         == $past(wr_data_in[`FEAT_SOFT_RST]);
   endproperty
   a_soft_rst: assert property (p_soft_rst)
      else $error("soft reset mismatch");

   property p_decode;
      @(posedge sys_clk_in) disable iff (!rst_n_in)
      s_write_hit |=> (decode_style_out == DECODE_HEX)
         == $past(wr_data_in[`FEAT_DECODE]);
   endproperty
   a_decode: assert property (p_decode)
      else $error("decode style mismatch");

   property p_blink_off_on;
      @(posedge sys_clk_in) disable iff (!rst_n_in)
      !feature_ff[`FEAT_BLINK_EN] |=> display_on_out;
   endproperty
   a_blink_off_on: assert property (p_blink_off_on)
      else $error("display dark while blink off");

   property p_start_phase;
      @(posedge sys_clk_in) disable iff (!rst_n_in)
      feature_ff[`FEAT_BLINK_EN] && timer_clear
         |=> display_on_out == $past(feature_ff[`FEAT_BLINK_PHASE]);
   endproperty
   a_start_phase: assert property (p_start_phase)
      else $error("wrong starting blink phase");

   property p_sync_clear;
      @(posedge sys_clk_in) disable iff (!rst_n_in)
      feature_ff[`FEAT_SYNC] && cs_rise |=> u_timer.count_ff == 32'h0;
   endproperty
   a_sync_clear: assert property (p_sync_clear)
      else $error("timer not cleared on chip-select rise");

   property p_toggle;
      @(posedge sys_clk_in) disable iff (!rst_n_in)
      feature_ff[`FEAT_BLINK_EN] && blink_en_d_ff && half_done
         && !timer_clear |=> display_on_out != $past(display_on_out);
   endproperty
   a_toggle: assert property (p_toggle)
      else $error("phase did not toggle at half period");

   // Reset release must leave the register clear and the display lit
   property p_power_up_clear;
      @(posedge sys_clk_in) disable iff (!rst_n_in)
      s_reset_left |-> feature_ff == `FEAT_RESET && display_on_out;
   endproperty
   a_power_up_clear: assert property (p_power_up_clear)
      else $error("feature register not clear after reset");

   // Writes to other addresses must leave the register alone
   property p_write_miss;
      @(posedge sys_clk_in) disable iff (!rst_n_in)
      s_write_miss |=> $stable(feature_ff);
   endproperty
   a_write_miss: assert property (p_write_miss)
      else $error("feature changed by foreign write");

   property p_read_miss;
      @(posedge sys_clk_in) disable iff (!rst_n_in)
      s_read_miss |=> rd_data_out == `RD_MISS_DATA && !rd_hit_out;
   endproperty
   a_read_miss: assert property (p_read_miss)
      else $error("unmapped read not zero");

   property p_read_flag;
      @(posedge sys_clk_in) disable iff (!rst_n_in)
      s_read_hit |=> rd_hit_out;
   endproperty
   a_read_flag: assert property (p_read_flag)
      else $error("read hit flag missing");

   // Read answer stands until the next read strobe
   property p_read_hold;
      @(posedge sys_clk_in) disable iff (!rst_n_in)
      rst_n_in && !rd_en_in |=> $stable(rd_data_out) && $stable(rd_hit_out);
   endproperty
   a_read_hold: assert property (p_read_hold)
      else $error("read answer moved without a read");

   property p_unused_zero;
      @(posedge sys_clk_in) disable iff (!rst_n_in)
      !feature_ff[`FEAT_UNUSED];
   endproperty
   a_unused_zero: assert property (p_unused_zero)
      else $error("unused feature bit set");

   property p_blink_flag;
      @(posedge sys_clk_in) disable iff (!rst_n_in)
      rst_n_in |=> blink_active_out == $past(feature_ff[`FEAT_BLINK_EN]);
   endproperty
   a_blink_flag: assert property (p_blink_flag)
      else $error("blink active flag wrong");

   // Between half periods the visible phase must not move
   property p_phase_hold;
      @(posedge sys_clk_in) disable iff (!rst_n_in)
      rst_n_in && feature_ff[`FEAT_BLINK_EN] && !timer_clear && !half_done
         |=> $stable(display_on_out);
   endproperty
   a_phase_hold: assert property (p_phase_hold)
      else $error("blink phase moved early");

   // rst_n_in in the antecedent skips the edge that still sees reset
   property p_count_step;
      @(posedge sys_clk_in) disable iff (!rst_n_in)
      rst_n_in && !timer_clear && !half_done
         |=> u_timer.count_ff == $past(u_timer.count_ff) + 32'h1;
   endproperty
   a_count_step: assert property (p_count_step)
      else $error("timing counter did not step");

   property p_no_sync;
      @(posedge sys_clk_in) disable iff (!rst_n_in)
      rst_n_in && !feature_ff[`FEAT_SYNC] && cs_rise && !blink_start
         && !half_done |=> u_timer.count_ff != 32'h0;
   endproperty
   a_no_sync: assert property (p_no_sync)
      else $error("timer cleared with sync off");

   property p_start_clear;
      @(posedge sys_clk_in) disable iff (!rst_n_in)
      blink_start |=> u_timer.count_ff == 32'h0;
   endproperty
   a_start_clear: assert property (p_start_clear)
      else $error("timer not cleared at blink start");

   property p_half_wrap;
      @(posedge sys_clk_in) disable iff (!rst_n_in)
      half_done |=> u_timer.count_ff == 32'h0;
   endproperty
   a_half_wrap: assert property (p_half_wrap)
      else $error("timer did not wrap at half period");
endmodule // feature_ctrl
`default_nettype wire

// file: testbench/cs_pin_host.sv
// Host side model that raises the load/chip-select pin on request
`timescale 1ns/1ps
`default_nettype none
module cs_pin_host (
   input wire logic go_in,
   output logic pin_out
);
   // Pin idles low and is held high for one link period per request
   // Non-blocking so the pin never races the design's sampling edge
   initial begin
      pin_out = 1'b0;
      forever begin
         @(posedge go_in);
         pin_out <= 1'b1;
         #160;
         pin_out <= 1'b0;
      end
   end
endmodule // cs_pin_host
`default_nettype wire

// file: testbench/led_driver_feature_control_bench.sv
// Self-checking bench for the feature control register block
`timescale 1ns/1ps
`default_nettype none
module led_driver_feature_control_bench;
   import feature_ctrl_pkg::*;
   localparam int unsigned SHORT = 8;
   localparam int unsigned LONG = 16;
   logic clk, rst_n, wr_en, rd_en, go, pin, hit, ext, rrst, keep, act, on;
   logic [7:0] addr;
   reg_byte_t wdat, rdat, d;
   decode_style_t dec;
   logic h;
   int errors, n_checks, n;
   feature_ctrl #(.SHORT_CYC(SHORT), .LONG_CYC(LONG)) i_feature_ctrl (
      .sys_clk_in(clk), .rst_n_in(rst_n), .wr_en_in(wr_en),
      .rd_en_in(rd_en), .addr_in(addr), .wr_data_in(wdat),
      .rd_data_out(rdat), .rd_hit_out(hit), .load_chip_select_pin_in(pin),
      .ext_clk_sel_out(ext), .ctrl_regs_reset_out(rrst),
      .digit_data_keep_out(keep), .decode_style_out(dec),
      .blink_active_out(act), .display_on_out(on));
   cs_pin_host i_cs_pin_host (.go_in(go), .pin_out(pin));
   //------------------------------------------------
   // Helpers
   //------------------------------------------------
   task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
      n_checks++;
      if (g !== e) begin
         errors++;
         $display("ERROR %s expected %h seen %h", s, e, g);
      end
   endtask
   task report_and_stop;
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   // One-cycle strobe; the register updates on the taking edge
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge clk);
      wr_en <= 1'b1; addr <= a; wdat <= v;
      @(posedge clk);
      wr_en <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge clk);
      rd_en <= 1'b1; addr <= a;
      @(posedge clk);
      rd_en <= 1'b0;
      @(negedge clk);
      d = rdat;
      h = hit;
   endtask
   // Bounded wait for the display to toggle; counts cycles taken
   task automatic wait_change(output int c);
      logic last;
      last = on;
      for (c = 0; c < 100 && on === last; c++) @(negedge clk);
      if (c == 100) begin
         errors++;
         report_and_stop();
      end
   endtask
   task automatic pulse;
      @(posedge clk) go <= 1'b1;
      @(posedge clk) go <= 1'b0;
      repeat (6) @(negedge clk); // Two sync stages plus edge detect
   endtask
   //------------------------------------------------
   // Scenarios
   //------------------------------------------------
   task t_regs;
      rd(8'h0e);
      chk("reset", 8'h00, d);
      chk("on", 8'h01, {7'h00, on});
      wr(8'h0e, 8'hff);
      rd(8'h0e);
      chk("feature", 8'hf7, d);
      chk("hit", 8'h01, {7'h00, h});
      chk("ext", 8'h01, {7'h00, ext});
      chk("rrst", 8'h01, {7'h00, rrst});
      chk("keep", 8'h01, {7'h00, keep});
      chk("dec", {7'h00, DECODE_HEX}, {7'h00, dec});
      wr(8'h0e, 8'h00);
      wr(8'h0a, 8'hff);
      rd(8'h0a);
      chk("unmapped", 8'h00, d);
      chk("miss", 8'h00, {7'h00, h});
      chk("ext", 8'h00, {7'h00, ext});
      chk("rrst", 8'h00, {7'h00, rrst});
      chk("dec", {7'h00, DECODE_CODE_B}, {7'h00, dec});
      $display("t_regs done");
   endtask
   task t_blink;
      wr(8'h0e, 8'h10);
      repeat (3) @(negedge clk);
      chk("phase", 8'h00, {7'h00, on});
      chk("act", 8'h01, {7'h00, act});
      wait_change(n);
      wait_change(n);
      chk("short", 8'(SHORT), 8'(n));
      wr(8'h0e, 8'h30);
      wait_change(n);
      wait_change(n);
      chk("long", 8'(LONG), 8'(n));
      wr(8'h0e, 8'h00);
      repeat (3) @(negedge clk);
      chk("steady", 8'h01, {7'h00, on});
      chk("act", 8'h00, {7'h00, act});
      wr(8'h0e, 8'h90);
      repeat (3) @(negedge clk);
      chk("phase", 8'h01, {7'h00, on});
      $display("t_blink done");
   endtask
   task t_sync;
      wr(8'h0e, 8'h00);
      wr(8'h0e, 8'h50);
      wait_change(n);
      // First change is the start phase load; wait for the on phase
      if (on !== 1'b1) wait_change(n);
      pulse();
      chk("sync", 8'h00, {7'h00, on});
      wr(8'h0e, 8'h10);
      wait_change(n);
      if (on !== 1'b1) wait_change(n);
      pulse();
      chk("nosync", 8'h01, {7'h00, on});
      $display("t_sync done");
   endtask
   task t_reset;
      wr(8'h0e, 8'hb7);
      rd(8'h0e);
      chk("pre", 8'hb7, d);
      @(posedge clk) rst_n <= 1'b0;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      rd(8'h0e);
      chk("rst feature", 8'h00, d);
      chk("rst on", 8'h01, {7'h00, on});
      $display("t_reset done");
   endtask
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   initial begin
      rst_n = 1'b0; wr_en = 1'b0; rd_en = 1'b0; go = 1'b0;
      addr = 8'h00; wdat = 8'h00; errors = 0; n_checks = 0;
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      t_regs();
      t_blink();
      t_sync();
      t_reset();
      report_and_stop();
   end
endmodule // led_driver_feature_control_bench
`default_nettype wire
